// File: sfs_dma_model.sv
// Bench model of the DMA controller that drains the receive buffer
`default_nettype none
module sfs_dma_model
  import sfs_pkg::*;
(
  input wire logic core_clk, // Channel clock
  input wire logic rst_b, // Async reset, active low
  input wire logic stall, // Bench holds off every transfer
  input wire logic rx_out_valid, // Byte offered
  input wire logic [SFS_DATA_W-1:0] rx_out_data, // Byte offered
  output logic rx_out_ready, // Byte taken at next edge
  output int n_taken, // Bytes taken so far
  output logic [SFS_DATA_W-1:0] last_byte // Last byte taken
);
  int ph;
  // ----------------------------------------------------------------
  // Ready pattern
  // ----------------------------------------------------------------
  // Refuses every third cycle so the buffer sees slow and prompt answers
  always @(negedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_out_ready <= 1'b0;
      ph <= 0;
    end
    else
    begin
      ph <= ph + 1;
      rx_out_ready <= !stall && (ph % 3 != 0);
    end
  end
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      n_taken <= 0;
    else if (rx_out_valid === 1'b1 && rx_out_ready)
    begin
      n_taken <= n_taken + 1;
      last_byte <= rx_out_data;
    end
  end
endmodule
`default_nettype wire

// File: sfs_frame_status_fifo.sv
// Frame status queue with byte counter, register readback and receive buffer
`default_nettype none
module sfs_frame_status_fifo
  import sfs_pkg::*;
#(
  parameter int unsigned DEPTH = SFS_DEPTH,
  parameter int unsigned DW = SFS_DATA_W
)(
  input wire logic core_clk, // Channel clock
  input wire logic rst_b, // Power-on reset, async, active low
  input wire logic chan_reset, // Channel reset, sync pulse
  input wire logic sdlc_mode, // Channel in SDLC/HDLC mode
  input wire logic feat_wr, // Write strobe of the enable bit
  input wire logic feat_wr_en, // Enable bit value written
  input wire logic [1:0] ie_rx_mode, // Interrupt enable bits 4:3
  input wire logic rx_in_valid, // Received byte valid
  output logic rx_in_ready, // Buffer can take a byte
  input wire logic [DW-1:0] rx_in_data, // Received byte
  input wire logic rx_in_eof, // Byte is last of frame
  input wire logic rx_in_err, // Byte has overrun or parity error
  output logic rx_out_valid, // Byte offered to DMA
  input wire logic rx_out_ready, // DMA takes byte
  output logic [DW-1:0] rx_out_data, // Byte to DMA
  output logic rx_out_eof, // Offered byte ends a frame
  input wire logic err_reset, // Error reset command
  input wire logic frame_end, // Closing flag seen, pulse
  input wire logic frame_abort, // Abort seen, pulse
  input wire logic [2:0] live_residue, // Live residue bits
  input wire logic live_overrun, // Live overrun flag
  input wire logic live_crc_err, // Live CRC error flag
  input wire logic live_all_sent, // Live all-sent flag
  input wire logic live_parity, // Live parity flag
  input wire logic live_eof, // Live end-of-frame flag
  input wire logic [7:0] live_xfer, // Transfer status register
  input wire logic [7:0] live_vector, // Interrupt vector readback
  input wire logic [7:0] live_pending, // Pending interrupt register
  input wire logic rd_strobe, // Register read, pulse
  input wire logic [3:0] rd_addr, // Read register index
  output logic [7:0] rd_data, // Read data, registered
  output logic crc_reset, // CRC checker restart, pulse
  output logic rxd_irq, // Receive-data interrupt, pulse
  output logic special_irq, // Special receive interrupt, pulse
  output logic fifo_active // Queue enabled and in SDLC mode
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned NW = $clog2(DEPTH + 1);
  localparam int unsigned BW = DW + 2;

  // ----------------------------------------------------------------
  // Status queue and byte counter
  // ----------------------------------------------------------------
  logic en_q, en_d;
  logic [SFS_ENTRY_W-1:0] mem_q [DEPTH];
  logic [SFS_ENTRY_W-1:0] mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [NW-1:0] n_q, n_d;
  logic ovf_q, ovf_d, arm_q, arm_d, crc_q, crc_d;
  logic [SFS_COUNT_W-1:0] bcnt_q, bcnt_d;
  logic active, push, push_ok, pop, stat_rd, upper_rd, empty, in_hs;
  logic [SFS_ENTRY_W-1:0] head;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign active = en_q && sdlc_mode;
  assign fifo_active = active;
  assign empty = (n_q == '0);
  assign head = mem_q[rp_q];
  assign in_hs = rx_in_valid && rx_in_ready;
  assign stat_rd = rd_strobe && (rd_addr == SFS_REG_STAT);
  assign upper_rd = rd_strobe && (rd_addr == SFS_REG_UPPER);
  assign push = active && (frame_end || frame_abort);
  // Pop needs an armed read sequence, so repeated status reads drain one
  assign pop = active && stat_rd && arm_q && !empty;
  assign push_ok = push && ((n_q != NW'(DEPTH)) || pop);

  always_comb
  begin
    en_d = en_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    n_d = n_q;
    ovf_d = ovf_q;
    arm_d = arm_q;
    bcnt_d = bcnt_q;
    crc_d = 1'b0;
    if (feat_wr)
    begin
      en_d = feat_wr_en;
    end
    if (in_hs)
    begin
      bcnt_d = bcnt_q + 1'b1;
    end
    if (frame_end || frame_abort)
    begin
      bcnt_d = '0;
      crc_d = 1'b1;
    end
    if (upper_rd && active)
    begin
      arm_d = !empty;
    end
    if (stat_rd)
    begin
      arm_d = 1'b0;
    end
    if (pop)
    begin
      rp_d = ptr_next(rp_q);
    end
    if (push_ok)
    begin
      // Only byte count, residue, overrun and CRC error are kept per frame
      mem_d[wp_q] = {bcnt_q, live_residue, live_overrun, live_crc_err};
      wp_d = ptr_next(wp_q);
    end
    else if (push)
    begin
      ovf_d = 1'b1;
    end
    n_d = n_q + NW'(push_ok) - NW'(pop);
    if (!active)
    begin
      // Disabling, leaving SDLC mode and a channel reset are the only ways software clears the overflow flag
      wp_d = '0;
      rp_d = '0;
      n_d = '0;
      arm_d = 1'b0;
      ovf_d = 1'b0;
    end
    if (chan_reset)
    begin
      en_d = SFS_EN_RST;
      wp_d = '0;
      rp_d = '0;
      n_d = '0;
      arm_d = 1'b0;
      ovf_d = 1'b0;
      bcnt_d = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q <= SFS_EN_RST;
      mem_q <= '{default: '0};
      wp_q <= '0;
      rp_q <= '0;
      n_q <= '0;
      ovf_q <= 1'b0;
      arm_q <= 1'b0;
      bcnt_q <= '0;
      crc_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q <= n_d;
      ovf_q <= ovf_d;
      arm_q <= arm_d;
      bcnt_q <= bcnt_d;
      crc_q <= crc_d;
    end
  end

  assign crc_reset = crc_q;

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  logic [7:0] rd_q, rd_d, stat_byte, upper_byte;
  logic from_fifo;

  assign from_fifo = active && !empty;
  // All-sent and parity always bypass the queue; EOF is live status forced set while the queue holds an entry
  assign stat_byte = {live_eof | from_fifo,
                      from_fifo ? head[0] : live_crc_err,
                      from_fifo ? head[1] : live_overrun,
                      live_parity,
                      from_fifo ? head[4:2] : live_residue,
                      live_all_sent};
  assign upper_byte = {ovf_q, !empty, head[SFS_ENTRY_W-1:SFS_ENTRY_W-6]};

  always_comb
  begin
    rd_d = rd_q;
    if (rd_strobe)
    begin
      case (rd_addr)
        SFS_REG_XFER, SFS_REG_IMG4: rd_d = live_xfer;
        SFS_REG_STAT, SFS_REG_IMG5: rd_d = stat_byte;
        SFS_REG_VECT: rd_d = live_vector;
        SFS_REG_PEND: rd_d = live_pending;
        SFS_REG_LOWER: rd_d = active ? head[12:5] : live_vector;
        SFS_REG_UPPER: rd_d = active ? upper_byte : live_pending;
        SFS_REG_RDBK:
        begin
          rd_d = 8'h00;
          rd_d[SFS_EN_BIT] = en_q;
        end
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

  // ----------------------------------------------------------------
  // Two-entry receive buffer with lock
  // ----------------------------------------------------------------
  logic [BW-1:0] buf_q [SFS_BUF_DEPTH];
  logic [BW-1:0] buf_d [SFS_BUF_DEPTH];
  logic bwp_q, bwp_d, brp_q, brp_d;
  logic [1:0] bn_q, bn_d;
  logic lock_q, lock_d, told_q, told_d, rxi_q, rxi_d, spi_q, spi_d;
  logic anti, out_hs, head_eof, head_err;

  assign anti = active && (ie_rx_mode == SFS_IE_SPECIAL_ONLY);
  assign head_eof = buf_q[brp_q][1];
  assign head_err = buf_q[brp_q][0];
  assign rx_in_ready = (bn_q != 2'(SFS_BUF_DEPTH));
  assign rx_out_valid = (bn_q != 2'h0) && !lock_q;
  assign rx_out_data = buf_q[brp_q][BW-1:2];
  assign rx_out_eof = head_eof;
  assign out_hs = rx_out_valid && rx_out_ready;

  always_comb
  begin
    buf_d = buf_q;
    bwp_d = bwp_q;
    brp_d = brp_q;
    lock_d = err_reset ? 1'b0 : lock_q;
    told_d = told_q;
    rxi_d = 1'b0;
    spi_d = 1'b0;
    if (in_hs)
    begin
      buf_d[bwp_q] = {rx_in_data, rx_in_eof, rx_in_err};
      bwp_d = !bwp_q;
    end
    if (out_hs)
    begin
      brp_d = !brp_q;
      told_d = 1'b0;
      spi_d = head_err;
      // A set in the cycle of the error reset still locks
      if (head_err || (head_eof && !anti))
      begin
        lock_d = 1'b1;
      end
    end
    // In special-only mode, one interrupt per EOF byte reaching the head
    if (anti && (bn_q != 2'h0) && head_eof && !told_q)
    begin
      rxi_d = 1'b1;
      told_d = !out_hs;
    end
    bn_d = bn_q + 2'(in_hs) - 2'(out_hs);
    if (chan_reset)
    begin
      bwp_d = 1'b0;
      brp_d = 1'b0;
      bn_d = 2'h0;
      lock_d = 1'b0;
      told_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buf_q <= '{default: '0};
      bwp_q <= 1'b0;
      brp_q <= 1'b0;
      bn_q <= 2'h0;
      lock_q <= 1'b0;
      told_q <= 1'b0;
      rxi_q <= 1'b0;
      spi_q <= 1'b0;
    end
    else
    begin
      buf_q <= buf_d;
      bwp_q <= bwp_d;
      brp_q <= brp_d;
      bn_q <= bn_d;
      lock_q <= lock_d;
      told_q <= told_d;
      rxi_q <= rxi_d;
      spi_q <= spi_d;
    end
  end

  assign rxd_irq = rxi_q;
  assign special_irq = spi_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_upper_rd;
    upper_rd && active && !empty && !chan_reset;
  endsequence
  sequence s_stat_rd;
    stat_rd && active && !push && !chan_reset && sdlc_mode && en_q && !feat_wr;
  endsequence
  // A gap cycle of a read sequence: queue stays on, no status read
  sequence s_quiet;
    active && !chan_reset && !stat_rd;
  endsequence

  property p_depth;
    n_q <= NW'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("queue over depth");

  property p_push;
    push && (n_q < NW'(DEPTH)) && !pop && !chan_reset |=> n_q == $past(n_q) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("push not stored");

  property p_crc;
    (frame_end || frame_abort) && !in_hs && !chan_reset |=> crc_reset && (bcnt_q == '0);
  endproperty
  a_crc: assert property (p_crc) else $error("frame end not restarted");

  property p_ovf;
    push && (n_q == NW'(DEPTH)) && !pop && !chan_reset && !feat_wr |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_dis;
    !active |=> (n_q == '0) && !ovf_q;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled queue not cleared");

  property p_chan;
    chan_reset |=> !en_q;
  endproperty
  a_chan: assert property (p_chan) else $error("enable survived reset");

  property p_img;
    rd_strobe && (rd_addr == SFS_REG_UPPER) && !active |=> rd_data == $past(live_pending);
  endproperty
  a_img: assert property (p_img) else $error("image read wrong");

  property p_rdbk;
    rd_strobe && (rd_addr == SFS_REG_RDBK) |=> rd_data[SFS_EN_BIT] == $past(en_q);
  endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback enable wrong");

  property p_one_pop;
    s_upper_rd ##1 s_quiet [*3] ##1 s_stat_rd ##1 s_quiet ##1 s_stat_rd |=> n_q == $past(n_q);
  endproperty
  a_one_pop: assert property (p_one_pop) else $error("second status read popped");

  property p_pop;
    s_upper_rd ##1 s_quiet [*3] ##1 s_stat_rd |=> n_q == $past(n_q) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("status read did not pop");

  property p_avail;
    rd_strobe && (rd_addr == SFS_REG_UPPER) && active |=> rd_data[SFS_AVAIL_BIT] == $past(!empty);
  endproperty
  a_avail: assert property (p_avail) else $error("available bit wrong");

  property p_lock;
    out_hs && head_err && !chan_reset ##1 !err_reset && !chan_reset |->
      !rx_out_valid ##1 !rx_out_valid;
  endproperty
  a_lock: assert property (p_lock) else $error("error byte did not lock");

  property p_anti;
    anti && out_hs && head_eof && !head_err && !lock_q |=> !lock_q;
  endproperty
  a_anti: assert property (p_anti) else $error("anti-lock failed");

  property p_rxi;
    anti && (bn_q != 2'h0) && head_eof && !told_q && !chan_reset |=> rxd_irq;
  endproperty
  a_rxi: assert property (p_rxi) else $error("no receive-data interrupt");

endmodule
`default_nettype wire

// File: sfs_pkg.sv
// Constants shared by the frame status queue block
`default_nettype none
package sfs_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned SFS_DEPTH = 10;
  localparam int unsigned SFS_ENTRY_W = 19;
  localparam int unsigned SFS_COUNT_W = 14;
  localparam int unsigned SFS_DATA_W = 8;
  localparam int unsigned SFS_BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // Read register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] SFS_REG_XFER = 4'h0;
  localparam logic [3:0] SFS_REG_STAT = 4'h1;
  localparam logic [3:0] SFS_REG_VECT = 4'h2;
  localparam logic [3:0] SFS_REG_PEND = 4'h3;
  localparam logic [3:0] SFS_REG_IMG4 = 4'h4;
  localparam logic [3:0] SFS_REG_IMG5 = 4'h5;
  localparam logic [3:0] SFS_REG_LOWER = 4'h6;
  localparam logic [3:0] SFS_REG_UPPER = 4'h7;
  localparam logic [3:0] SFS_REG_RDBK = 4'hf;
  // ----------------------------------------------------------------
  // Field positions, mode codes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SFS_EN_BIT = 2;
  localparam int unsigned SFS_AVAIL_BIT = 6;
  localparam int unsigned SFS_OVF_BIT = 7;
  localparam logic [1:0] SFS_IE_SPECIAL_ONLY = 2'h3;
  localparam logic SFS_EN_RST = 1'b0;
endpackage
`default_nettype wire

// File: tb.sv
// Self-checking bench for the frame status queue
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfs_pkg::*;
  logic core_clk = 0, rst_b = 0, chan_reset = 0, sdlc_mode = 0, feat_wr = 0, feat_wr_en = 0;
  logic [1:0] ie_rx_mode = 0;
  logic rx_in_valid = 0, rx_in_ready, rx_in_eof = 0, rx_in_err = 0, rx_out_valid, rx_out_ready;
  logic [7:0] rx_in_data = 0, rx_out_data, rd_data, live_xfer = 0, live_vector = 0;
  logic [7:0] live_pending = 0, d, last_sent, last_byte;
  logic rx_out_eof, err_reset = 0, frame_end = 0, frame_abort = 0, rd_strobe = 0;
  logic [2:0] live_residue = 0;
  logic live_overrun = 0, live_crc_err = 0, live_all_sent = 0, live_parity = 0, live_eof = 0;
  logic [3:0] rd_addr = 0;
  logic crc_reset, rxd_irq, special_irq, fifo_active, stall = 0, ovf = 0;
  int n_mismatch = 0, n_compared = 0, n_rxd = 0, n_spec = 0, n_taken, cnt = 0, n_sent = 0;
  logic [31:0] seed = 32'h3d00;
  logic [18:0] exp_q[$];

  sfs_frame_status_fifo dut_u (.core_clk, .rst_b, .chan_reset, .sdlc_mode, .feat_wr,
    .feat_wr_en, .ie_rx_mode, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_in_eof, .rx_in_err,
    .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_eof, .err_reset, .frame_end,
    .frame_abort, .live_residue, .live_overrun, .live_crc_err, .live_all_sent, .live_parity,
    .live_eof, .live_xfer, .live_vector, .live_pending, .rd_strobe, .rd_addr, .rd_data,
    .crc_reset, .rxd_irq, .special_irq, .fifo_active);
  sfs_dma_model dma_u (.core_clk, .rst_b, .stall, .rx_out_valid, .rx_out_data, .rx_out_ready,
    .n_taken, .last_byte);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (rxd_irq === 1'b1) n_rxd++;
    if (special_irq === 1'b1) n_spec++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Queue fields come from the entry, EOF is live status forced by a queued entry, the rest from live status
  function automatic logic [7:0] stat_exp(logic [2:0] res, logic ovr, logic crc, logic q);
    return {q | live_eof, crc, ovr, live_parity, res, live_all_sent};
  endfunction
  task automatic finish_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Idle cycle after the strobe so back-to-back reads never retoggle in one step
  task automatic rd(logic [3:0] a);
    rd_strobe = 1;
    rd_addr = a;
    cyc(1);
    rd_strobe = 0;
    cyc(1);
    d = rd_data;
  endtask
  task automatic live_rand();
    seed = lfsr(seed);
    {live_residue, live_overrun, live_crc_err, live_all_sent, live_parity, live_eof} = seed[8:0];
    {live_xfer, live_vector, live_pending} = seed[31:8];
  endtask
  task automatic send(int n, logic eof, logic err);
    int w;
    rx_in_valid = 1;
    rx_in_eof = eof;
    rx_in_err = err;
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      rx_in_data = seed[7:0];
      w = 0;
      while (!rx_in_ready && w < 50)
      begin
        cyc(1);
        w++;
      end
      cyc(1);
      cnt++;
      n_sent++;
      last_sent = rx_in_data;
    end
    rx_in_valid = 0;
    rx_in_eof = 0;
    rx_in_err = 0;
  endtask
  task automatic frame(logic abort);
    live_rand();
    frame_end = !abort;
    frame_abort = abort;
    if (fifo_active)
    begin
      if (exp_q.size() == SFS_DEPTH) ovf = 1;
      else exp_q.push_back({cnt[13:0], live_residue, live_overrun, live_crc_err});
    end
    cnt = 0;
    cyc(1);
    frame_end = 0;
    frame_abort = 0;
    chk(crc_reset, 1);
    cyc(1);
    chk(crc_reset, 0);
  endtask
  task automatic pop_check();
    logic [18:0] e;
    e = exp_q.pop_front();
    live_rand();
    rd(SFS_REG_UPPER);
    chk(d, {ovf, 1'b1, e[18:13]});
    rd(SFS_REG_LOWER);
    chk(d, e[12:5]);
    rd(SFS_REG_STAT);
    chk(d, stat_exp(e[4:2], e[1], e[0], 1));
  endtask
  task automatic empty_check();
    live_rand();
    rd(SFS_REG_UPPER);
    chk(d[7:6], {ovf, 1'b0});
    rd(SFS_REG_STAT);
    chk(d, stat_exp(live_residue, live_overrun, live_crc_err, 0));
  endtask
  task automatic mirror();
    logic [7:0] img[4];
    live_rand();
    img = '{live_xfer, stat_exp(live_residue, live_overrun, live_crc_err, 0), live_vector,
      live_pending};
    for (int i = 0; i < 4; i++)
    begin
      rd(4'(i + 4));
      chk(d, img[i]);
    end
  endtask
  task automatic set_en(logic v);
    feat_wr = 1;
    feat_wr_en = v;
    cyc(1);
    feat_wr = 0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    cyc(2);
    rst_b = 1;
    cyc(1);
    rd(SFS_REG_RDBK);
    chk(d, 8'h00);
    rd(4'h9);
    chk(d, 8'h00);
    sdlc_mode = 1;
    mirror();
    set_en(1);
    chk(fifo_active, 1);
    rd(SFS_REG_RDBK);
    chk(d, 8'h04);
    sdlc_mode = 0;
    cyc(1);
    chk(fifo_active, 0);
    mirror();
    sdlc_mode = 1;
    cyc(1);
    empty_check();
    stall = 1;
    send(2, 0, 0);
    chk(rx_in_ready, 0);
    stall = 0;
    for (int f = 0; f < 11; f++)
    begin
      seed = lfsr(seed);
      send(1 + int'(seed[2:0] % 6), 0, 0);
      frame(f % 3 == 2);
    end
    pop_check();
    rd(SFS_REG_STAT);
    chk(d, stat_exp(exp_q[0][4:2], exp_q[0][1], exp_q[0][0], 1));
    repeat (9) pop_check();
    empty_check();
    set_en(0);
    set_en(1);
    ovf = 0;
    rd(SFS_REG_UPPER);
    chk(d[7:6], 2'b00);
    ie_rx_mode = SFS_IE_SPECIAL_ONLY;
    send(1, 1, 0);
    cyc(8);
    chk(8'(n_rxd), 1);
    send(1, 0, 0);
    cyc(8);
    chk(8'(n_taken), 8'(n_sent));
    send(1, 0, 1);
    cyc(8);
    send(1, 0, 0);
    cyc(8);
    chk(rx_out_valid, 0);
    err_reset = 1;
    cyc(1);
    err_reset = 0;
    cyc(8);
    chk(8'(n_spec), 1);
    chk(8'(n_taken), 8'(n_sent));
    chk(last_byte, last_sent);
    chan_reset = 1;
    cyc(1);
    chan_reset = 0;
    chk(fifo_active, 0);
    rd(SFS_REG_RDBK);
    chk(d, 8'h00);
    finish_test();
  end
  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
